// [hdl/sram_ctrl_pkg.sv]
// Purpose: shared constants and types of the burst / mode / sleep control block
// Assumes: one 20 MHz clock, active-low asynchronous reset
// Notes:   data lane is 9 bits, top bit of each lane is the parity bit
package sram_ctrl_pkg;

  // -----------------------------------------------------------------
  // widths
  // -----------------------------------------------------------------
  localparam int LANES   = 4;              // byte lanes on the data bus
  localparam int LANE_W  = 9;              // 8 data bits plus one parity bit
  localparam int DATA_W  = LANES * LANE_W; // full data bus width
  localparam int ADDR_W  = 18;             // default word address width
  localparam int BURST_W = 2;              // burst counter width

  // -----------------------------------------------------------------
  // reset values and counter steps
  // -----------------------------------------------------------------
  localparam logic [BURST_W-1:0] COUNT_RST = 2'h0; // counter after load or reset
  localparam logic [BURST_W-1:0] COUNT_ONE = 2'h1; // counter step per advance
  localparam int SLEEP_ENTRY_CYCLES = 2;           // edges from request to sleep

  // -----------------------------------------------------------------
  // kind of burst in progress, decides what a continue cycle does
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_READ,
    KIND_WRITE
  } burst_kind_t;

endpackage

// [hdl/burst_if.sv]
// Purpose: carries load/advance and the low address bits to the burst counter
// Assumes: all members change on the one block clock
// Notes:   the user side gates load and step with the clock enable
`timescale 1ns/1ps
interface burst_if import sram_ctrl_pkg::*; ();
  logic               load;     // take the external low bits as burst start
  logic               step;     // advance the counter this edge
  logic               order;    // high: interleaved, low: linear
  logic [BURST_W-1:0] ext_low;  // low address bits from the pins
  logic [BURST_W-1:0] low_addr; // low bits of this cycle's access
  logic [BURST_W-1:0] count;    // current step count
  modport gen  (input load, step, order, ext_low, output low_addr, count);
  modport user (output load, step, order, ext_low, input low_addr, count);
endinterface

// [hdl/burst_addr_gen.sv]
// Purpose: two-bit burst counter giving linear or interleaved low address bits
// Assumes: load and step already qualified by clock enable and sleep
// Notes:   the low address is combinational so the access uses it this edge
`timescale 1ns/1ps
module burst_addr_gen import sram_ctrl_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  burst_if.gen     bif
);

  logic [BURST_W-1:0] count_q; // steps taken since the load
  logic [BURST_W-1:0] count_d;
  logic [BURST_W-1:0] base_q;  // loaded low bits
  logic [BURST_W-1:0] base_d;

  // -----------------------------------------------------------------
  // next counter state and access address
  // -----------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    base_d  = base_q;
    if (bif.load) begin
      base_d  = bif.ext_low;
      count_d = COUNT_RST;
    end else if (bif.step) begin
      count_d = count_q + COUNT_ONE; // natural wrap after four
    end
    // interleave xors the step into the start, linear adds it
    bif.low_addr = bif.order ? (base_d ^ count_d) : (base_d + count_d);
  end

  assign bif.count = count_q;

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= COUNT_RST;
      base_q  <= COUNT_RST;
    end else begin
      count_q <= count_d;
      base_q  <= base_d;
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  chk_adv_count: assert property ((bif.step && !bif.load) |=>
    bif.count == $past(bif.count) + COUNT_ONE)
    else $error("burst counter did not advance");

  chk_wrap_four: assert property (
    bif.load ##1 (bif.step && !bif.load)[*4] |=> bif.count == COUNT_RST)
    else $error("burst counter did not wrap after four accesses");

endmodule

// [hdl/sleep_ctrl.sv]
// Purpose: two-edge sleep entry and exit from the sleep request pin
// Assumes: request is sampled as a synchronous input
// Notes:   stage one is a plain delay, the top reads it to go quiet on time
`timescale 1ns/1ps
module sleep_ctrl import sram_ctrl_pkg::*; (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_clk_en,
  input  wire logic i_sleep_request,
  output logic      o_sleep_pending,
  output logic      o_sleep_active
);

  logic seen_d;  // next value of the first stage
  logic sleep_d; // next value of the sleep flag

  // -----------------------------------------------------------------
  // two stage delay, frozen with the rest of the block
  // -----------------------------------------------------------------
  always_comb begin
    seen_d  = o_sleep_pending;
    sleep_d = o_sleep_active;
    if (i_clk_en) begin
      seen_d  = i_sleep_request; // active high, level held
      sleep_d = o_sleep_pending; // second edge enters sleep
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sleep_pending <= 1'b0;
      o_sleep_active  <= 1'b0;
    end else begin
      o_sleep_pending <= seen_d;
      o_sleep_active  <= sleep_d;
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  chk_sleep_entry: assert property (
    (i_clk_en && i_sleep_request)[*2] |=> o_sleep_active)
    else $error("sleep not entered two edges after request");

  chk_sleep_level: assert property (
    (i_clk_en && !i_sleep_request)[*2] |=> !o_sleep_active)
    else $error("sleep held after request dropped");

endmodule

// [hdl/sram_burst_sleep_mode_ctrl.sv]
// Purpose: burst address, mode pin and sleep control of a no-turnaround SRAM
// Assumes: mode pins static, all pins synchronous, core reads combinationally
// Notes:   core strobes are levels; the core must qualify them with i_clk_en
`timescale 1ns/1ps
module sram_burst_sleep_mode_ctrl import sram_ctrl_pkg::*; #(
  parameter int AW = ADDR_W, // word address width
  parameter int DW = DATA_W  // data width, lanes of nine bits
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_clk_en,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic          i_advance_load_select,
  input  wire logic          i_write_n,
  input  wire logic [LANES-1:0] i_byte_we_n,
  input  wire logic          i_chip_en1_n,
  input  wire logic          i_chip_en2,
  input  wire logic          i_chip_en3_n,
  input  wire logic          i_burst_order_select,
  input  wire logic          i_flow_through_select,
  input  wire logic          i_sleep_request,
  input  wire logic          i_parity_lane_enable_n,
  input  wire logic [DW-1:0] i_dq,
  output logic      [DW-1:0] o_dq,
  output logic               o_dq_oe,
  output logic               o_dqp_oe,
  output logic      [AW-1:0] o_core_raddr,
  output logic               o_core_rd,
  input  wire logic [DW-1:0] i_core_rdata,
  output logic      [AW-1:0] o_core_waddr,
  output logic      [DW-1:0] o_core_wdata,
  output logic   [LANES-1:0] o_core_wbe,
  output logic               o_core_we,
  output logic               o_sleep_active
);

  // -----------------------------------------------------------------
  // sleep sequencing
  // -----------------------------------------------------------------
  logic sleep_pending; // request seen one edge ago
  logic hold;          // freeze state and keep the pins quiet
  logic go;            // this edge may change state

  sleep_ctrl u_sleep (
    .i_ref_clk       (i_ref_clk),
    .i_rst_n         (i_rst_n),
    .i_clk_en        (i_clk_en),
    .i_sleep_request (i_sleep_request),
    .o_sleep_pending (sleep_pending),
    .o_sleep_active  (o_sleep_active)
  );

  // entering and leaving both take two edges; the controller must have
  // drained its work first because a frozen pipeline never completes it
  assign hold = sleep_pending | o_sleep_active;
  assign go   = i_clk_en & ~hold;

  // -----------------------------------------------------------------
  // mode pins
  // -----------------------------------------------------------------
  logic ft_mode;   // flow-through output path
  logic parity_on; // parity lanes in use

  // pull-up on the flow-through select and pull-down on the parity enable
  // sit outside; here only the levels matter
  assign ft_mode   = ~i_flow_through_select;
  assign parity_on = ~i_parity_lane_enable_n;

  // -----------------------------------------------------------------
  // burst counter
  // -----------------------------------------------------------------
  burst_if bif ();
  burst_kind_t kind_q; // burst kind in progress
  burst_kind_t kind_d;

  assign bif.load    = go & ~i_advance_load_select;
  // a deselect continue is no burst cycle and leaves the counter alone
  assign bif.step    = go & i_advance_load_select & (kind_q != KIND_NONE);
  assign bif.order   = i_burst_order_select;
  assign bif.ext_low = i_addr[BURST_W-1:0];

  burst_addr_gen u_burst (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .bif       (bif)
  );

  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  logic               selected;   // all three chip enables active
  logic [AW-1:BURST_W] upper_q;   // upper address of the burst
  logic [AW-1:BURST_W] upper_d;
  logic [AW-1:0]      acc_addr;   // address of this edge's access
  logic               rd_cmd;     // read taken this edge
  logic               wr_cmd;     // write taken this edge
  logic [LANES-1:0]   be_cmd;     // byte enables of that write

  assign selected = ~i_chip_en1_n & i_chip_en2 & ~i_chip_en3_n;

  always_comb begin
    kind_d  = kind_q;
    upper_d = upper_q;
    rd_cmd  = 1'b0;
    wr_cmd  = 1'b0;
    be_cmd  = '0;
    if (go && !i_advance_load_select) begin
      // begin cycle: new address, kind from the command pins
      upper_d = i_addr[AW-1:BURST_W];
      if (!selected) begin
        kind_d = KIND_NONE; // deselect
      end else if (i_write_n) begin
        kind_d = KIND_READ;
        rd_cmd = 1'b1;
      end else begin
        kind_d = KIND_WRITE;
        wr_cmd = 1'b1;
        be_cmd = ~i_byte_we_n;
      end
    end else if (go) begin
      // continue cycle keeps the kind the burst started with
      unique case (kind_q)
        KIND_READ: begin
          rd_cmd = 1'b1;
        end
        KIND_WRITE: begin
          wr_cmd = 1'b1;
          be_cmd = ~i_byte_we_n; // all high is a write abort
        end
        KIND_NONE: begin
          rd_cmd = 1'b0;
        end
      endcase
    end
    // only the two low bits move during a burst
    acc_addr = {upper_d, bif.low_addr};
  end

  // -----------------------------------------------------------------
  // write and read pipelines
  // -----------------------------------------------------------------
  logic             wr1_q, wr1_d;   // write one edge old
  logic             wr2_q, wr2_d;   // write two edges old
  logic [AW-1:0]    wa1_q, wa1_d;   // its address
  logic [AW-1:0]    wa2_q, wa2_d;
  logic [LANES-1:0] be1_q, be1_d;   // its byte enables
  logic [LANES-1:0] be2_q, be2_d;
  logic             rd2_q, rd2_d;   // read one edge behind the core strobe
  logic [DW-1:0]    rdat_q, rdat_d; // pipelined read data stage
  logic [AW-1:0]    raddr_d;
  logic             rd_d, we_d, oe_d, poe_d;
  logic [AW-1:0]    waddr_d;
  logic [DW-1:0]    wdata_d, dq_d, dq_src;
  logic [LANES-1:0] wbe_d;
  logic             wcap;           // write data is on the pins now

  always_comb begin
    wr1_d   = wr1_q;
    wr2_d   = wr2_q;
    wa1_d   = wa1_q;
    wa2_d   = wa2_q;
    be1_d   = be1_q;
    be2_d   = be2_q;
    rd2_d   = rd2_q;
    rdat_d  = rdat_q;
    raddr_d = o_core_raddr;
    rd_d    = o_core_rd;
    we_d    = o_core_we;
    oe_d    = o_dq_oe;
    poe_d   = o_dqp_oe;
    waddr_d = o_core_waddr;
    wdata_d = o_core_wdata;
    wbe_d   = o_core_wbe;
    dq_d    = o_dq;
    // flow-through takes write data one edge after the command,
    // pipelined two edges after
    wcap    = ft_mode ? wr1_q : wr2_q;
    // flow-through drives what the core returns now, pipelined what
    // it returned an edge ago
    dq_src  = ft_mode ? i_core_rdata : rdat_q;
    // parity bit of each lane is blanked while the lanes are off
    for (int i = 0; i < LANES; i++) begin
      if (!parity_on) begin
        dq_src[i*LANE_W+LANE_W-1] = 1'b0;
      end
    end
    if (i_clk_en && hold) begin
      // quiet the pins and core but keep every address and stage
      rd_d  = 1'b0;
      we_d  = 1'b0;
      oe_d  = 1'b0;
      poe_d = 1'b0;
    end else if (go) begin
      raddr_d = acc_addr;
      rd_d    = rd_cmd;
      wr1_d   = wr_cmd;
      wa1_d   = acc_addr;
      be1_d   = be_cmd;
      wr2_d   = wr1_q;
      wa2_d   = wa1_q;
      be2_d   = be1_q;
      rd2_d   = o_core_rd;
      rdat_d  = i_core_rdata;
      waddr_d = ft_mode ? wa1_q : wa2_q;
      wbe_d   = ft_mode ? be1_q : be2_q;
      we_d    = wcap & (|wbe_d); // abort writes nothing
      wdata_d = i_dq;
      for (int i = 0; i < LANES; i++) begin
        if (!parity_on) begin
          wdata_d[i*LANE_W+LANE_W-1] = 1'b0;
        end
      end
      dq_d  = dq_src;
      oe_d  = ft_mode ? o_core_rd : rd2_q;
      poe_d = oe_d & parity_on;
    end
  end

  // -----------------------------------------------------------------
  // registers; CKE low holds everything, so a stalled read stays driven
  // -----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      kind_q       <= KIND_NONE;
      upper_q      <= '0;
      wr1_q        <= 1'b0;
      wr2_q        <= 1'b0;
      wa1_q        <= '0;
      wa2_q        <= '0;
      be1_q        <= '0;
      be2_q        <= '0;
      rd2_q        <= 1'b0;
      rdat_q       <= '0;
      o_core_raddr <= '0;
      o_core_rd    <= 1'b0;
      o_core_we    <= 1'b0;
      o_core_waddr <= '0;
      o_core_wdata <= '0;
      o_core_wbe   <= '0;
      o_dq         <= '0;
      o_dq_oe      <= 1'b0;
      o_dqp_oe     <= 1'b0;
    end else begin
      kind_q       <= kind_d;
      upper_q      <= upper_d;
      wr1_q        <= wr1_d;
      wr2_q        <= wr2_d;
      wa1_q        <= wa1_d;
      wa2_q        <= wa2_d;
      be1_q        <= be1_d;
      be2_q        <= be2_d;
      rd2_q        <= rd2_d;
      rdat_q       <= rdat_d;
      o_core_raddr <= raddr_d;
      o_core_rd    <= rd_d;
      o_core_we    <= we_d;
      o_core_waddr <= waddr_d;
      o_core_wdata <= wdata_d;
      o_core_wbe   <= wbe_d;
      o_dq         <= dq_d;
      o_dq_oe      <= oe_d;
      o_dqp_oe     <= poe_d;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  chk_load_start_addr: assert property (
    (go && !i_advance_load_select) |=> o_core_raddr == $past(i_addr))
    else $error("burst start address not loaded");

  chk_upper_held: assert property (
    (go && i_advance_load_select) |=>
      o_core_raddr[AW-1:BURST_W] == $past(o_core_raddr[AW-1:BURST_W]))
    else $error("upper address moved during burst");

  chk_linear_step: assert property (
    (bif.step && !i_burst_order_select) |=>
      o_core_raddr[1:0] == $past(o_core_raddr[1:0]) + 2'h1)
    else $error("linear burst did not add one");

  chk_ilv_step: assert property (
    (bif.step && i_burst_order_select) |=>
      (o_core_raddr[1:0] ^ $past(o_core_raddr[1:0])) == (bif.count ^ $past(bif.count)))
    else $error("interleaved burst not start xor count");

  chk_ft_read_lat: assert property (
    (rd_cmd && ft_mode) ##1 go |=> o_dq_oe)
    else $error("flow-through read not driven after one edge");

  chk_pipe_read_lat: assert property (
    (rd_cmd && !ft_mode) ##1 go [*2] |=> o_dq_oe)
    else $error("pipelined read not driven after two edges");

  chk_sleep_quiet: assert property (
    o_sleep_active |-> !o_dq_oe && !o_dqp_oe && !o_core_we && !o_core_rd)
    else $error("pins or core active while asleep");

  chk_sleep_keeps: assert property (
    (o_sleep_active && $past(o_sleep_active)) |->
      $stable(o_core_raddr) && $stable(bif.count) && $stable(kind_q))
    else $error("state changed while asleep");

  chk_parity_off: assert property (
    (i_clk_en && i_parity_lane_enable_n) |=> !o_dqp_oe)
    else $error("parity lanes driven while disabled");

endmodule

// [testbench/sram_ctrl_master_model.sv]
// Purpose: memory controller model that drives the command and sleep pins
// Assumes: every change is launched just after a rising clock edge
// Notes:   the bench calls the tasks below by hierarchical reference
`timescale 1ns/1ps
module sram_ctrl_master_model #(
  parameter int DRAIN = 2, // idle edges before a sleep request
  parameter int RECOV = 3  // recovery edges, reads or deselects only
) (
  input  wire logic        i_clk,
  output logic             o_adv,
  output logic             o_write_n,
  output logic [3:0]       o_bwe_n,
  output logic             o_en1_n,
  output logic             o_en2,
  output logic             o_en3_n,
  output logic [17:0]      o_addr,
  output logic [35:0]      o_dq,
  output logic             o_sleep_request
);
  // -------------------------------------------------------------
  // idle: deselect begin, sleep request low, like the pull-down
  // -------------------------------------------------------------
  initial begin
    {o_adv, o_en2, o_sleep_request} = 3'h0;
    {o_write_n, o_en1_n, o_en3_n} = 3'h7;
    o_bwe_n = 4'hf;
    o_addr  = 18'h0;
    o_dq    = 36'h0;
  end

  // one command: adv low begins with the given address
  task automatic issue(input logic advance_load_select, wn, input logic [3:0] bw, input logic sel,
                       input logic [17:0] a, input logic [35:0] d);
    @(posedge i_clk);
    o_adv     <= advance_load_select;
    o_write_n <= wn;
    o_bwe_n   <= bw;
    o_en1_n   <= ~sel;
    o_en2     <= sel;
    o_en3_n   <= ~sel;
    o_addr    <= a;
    o_dq      <= d;
  endtask

  // hold off for the pipe depth, then raise a level request
  task automatic sleep_enter();
    repeat (DRAIN) @(posedge i_clk);
    o_sleep_request <= 1'b1;
  endtask

  // lower the request and keep to reads while recovering
  task automatic sleep_exit();
    @(posedge i_clk);
    o_sleep_request <= 1'b0;
    o_write_n       <= 1'b1;
    repeat (RECOV) @(posedge i_clk);
  endtask
endmodule

// [testbench/testbench.sv]
// Purpose: self-checking bench for burst, mode pin and sleep control
// Assumes: core read data is a fixed function of the read address
// Notes:   mode pins only change under reset, so each mode gets a reset
`timescale 1ns/1ps
module testbench;
  localparam logic [35:0] PMASK = 36'h804020100; // parity bit of each lane
  logic        clk;   // 20 MHz block clock
  logic        rst_n; // active-low reset
  logic        en;    // clock enable
  logic        order; // burst order select
  logic        ft;    // flow-through select
  logic        pe_n;  // parity lanes enable, active low
  logic        advance_load_select, wn, e1n, e2, e3n, req;
  logic [3:0]  bwn;
  logic [17:0] addr, raddr, waddr;
  logic [35:0] dq, dq_out, wdata, rdata;
  logic [3:0]  wbe;
  logic        dq_oe, dqp_oe, rd, we, asleep;
  int          err_total;
  int          compares;

  // core model: data is the address and its inverse
  assign rdata = {raddr, ~raddr};

  always #25 clk = ~clk;

  sram_ctrl_master_model ctl (.i_clk(clk), .o_adv(advance_load_select), .o_write_n(wn), .o_bwe_n(bwn),
    .o_en1_n(e1n), .o_en2(e2), .o_en3_n(e3n), .o_addr(addr), .o_dq(dq),
    .o_sleep_request(req));

  sram_burst_sleep_mode_ctrl uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(en),
    .i_addr(addr), .i_advance_load_select(advance_load_select), .i_write_n(wn), .i_byte_we_n(bwn),
    .i_chip_en1_n(e1n), .i_chip_en2(e2), .i_chip_en3_n(e3n),
    .i_burst_order_select(order), .i_flow_through_select(ft), .i_sleep_request(req),
    .i_parity_lane_enable_n(pe_n), .i_dq(dq), .o_dq(dq_out), .o_dq_oe(dq_oe),
    .o_dqp_oe(dqp_oe), .o_core_raddr(raddr), .o_core_rd(rd), .i_core_rdata(rdata),
    .o_core_waddr(waddr), .o_core_wdata(wdata), .o_core_wbe(wbe), .o_core_we(we),
    .o_sleep_active(asleep));

  // -------------------------------------------------------------
  // compare and verdict
  // -------------------------------------------------------------
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // static pins are set under reset; strobes, output enables and the sleep flag must be quiet after it
  task automatic do_reset(input logic f, input logic o, input logic p);
    @(posedge clk);
    rst_n <= 1'b0;
    ft    <= f;
    order <= o;
    pe_n  <= p;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({rd, dq_oe, dqp_oe, we, asleep}, 36'h0);
  endtask

  // load then five advancing edges, address pins scrambled meanwhile
  task automatic burst(input logic [17:0] b);
    logic [1:0] lo;
    ctl.issue(1'b0, 1'b1, 4'hf, 1'b1, b, 36'h0);
    for (int k = 0; k < 5; k++) begin
      ctl.issue(1'b1, 1'b1, 4'hf, 1'b1, ~b, 36'h0);
      #1 lo = order ? (b[1:0] ^ k[1:0]) : (b[1:0] + k[1:0]);
      chk(raddr, {b[17:2], lo});
      chk(rd, 1'b1);
    end
  endtask

  // single access; write data is right only on the edge it must be taken
  task automatic single(input logic wr, input logic [17:0] a, input logic [3:0] bw,
                        input logic [35:0] d);
    int lat;
    logic [35:0] m;
    lat = ft ? 2 : 1;
    m   = pe_n ? ~PMASK : ~36'h0;
    ctl.issue(1'b0, ~wr, bw, 1'b1, a, ~d);
    for (int i = 0; i <= lat; i++) begin
      ctl.issue(1'b0, 1'b1, 4'hf, 1'b0, a, (i == lat - 1) ? d : ~d);
      #1 if (i == 0 && !wr) chk(raddr, a);
    end
    if (wr) begin
      chk(we, |(~bw));
      if (|(~bw)) begin
        chk({waddr, wbe}, {a, ~bw});
        chk(wdata, d & m);
      end
    end else begin
      chk(dq_out, {a, ~a} & m);
      chk({dq_oe, dqp_oe}, {1'b1, ~pe_n});
    end
  endtask

  // -------------------------------------------------------------
  // sleep entry, quiet pins, and a burst that survives it
  // -------------------------------------------------------------
  task automatic sleep_test(input logic [17:0] b);
    ctl.issue(1'b0, 1'b1, 4'hf, 1'b1, b, 36'h0);
    ctl.issue(1'b1, 1'b1, 4'hf, 1'b1, b, 36'h0);
    ctl.sleep_enter();
    @(posedge clk);
    #1 chk(asleep, 1'b0);
    chk(raddr, {b[17:2], b[1:0] + 2'h3});
    @(posedge clk);
    #1 chk({asleep, rd, dq_oe, dqp_oe, we}, 36'h10);
    repeat (3) @(posedge clk);
    #1 chk({asleep, rd, dq_oe}, 36'h4);
    ctl.sleep_exit();
    #1 chk({asleep, rd}, 36'h1);
    chk(raddr, b);
  endtask

  // clock enable low mid-burst: nothing moves, the burst resumes after
  task automatic stall_test(input logic [17:0] a);
    ctl.issue(1'b0, 1'b1, 4'hf, 1'b1, a, 36'h0);
    ctl.issue(1'b1, 1'b1, 4'hf, 1'b1, a, 36'h0);
    @(posedge clk);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({raddr, rd}, {a[17:2], a[1:0] + 2'h1, 1'b1});
    @(posedge clk);
    en <= 1'b1;
    @(posedge clk);
    #1 chk(raddr, {a[17:2], a[1:0] + 2'h2});
  endtask

  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial begin
    {clk, rst_n, order, pe_n} = 4'h0;
    {en, ft} = 2'h3;
    err_total = 0;
    compares  = 0;
    do_reset(1'b1, 1'b0, 1'b0);
    burst(18'h23452);
    single(1'b0, 18'h01234, 4'h0, 36'h0);
    single(1'b1, 18'h3abcd, 4'h0, 36'h9a5c3f1e7);
    single(1'b1, 18'h00011, 4'hf, 36'h123456789);
    stall_test(18'h2aaa9);
    $display("test pipelined linear done");
    sleep_test(18'h10001);
    $display("test sleep done");
    do_reset(1'b0, 1'b1, 1'b1);
    burst(18'h15556);
    single(1'b0, 18'h2f0f1, 4'hf, 36'h0);
    single(1'b1, 18'h0c003, 4'h5, 36'hfffffffff);
    $display("test flow-through interleaved done");
    finish_test();
  end
endmodule
